// ===== verilog/timer_capture_map.svh
/*
 * Register indices, field positions, reset values and prescale codes
 * for the input-capture timer channels 2 to 5.
 * Assumes APB byte address = 4 * register index.
 */
`ifndef TIMER_CAPTURE_MAP_SVH
`define TIMER_CAPTURE_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDX_CHAN2_SC      14'h0456
`define IDX_CHAN2_HI      14'h0457
`define IDX_CHAN2_LO      14'h0458
`define IDX_CHAN3_SC      14'h0459
`define IDX_CHAN3_HI      14'h045A
`define IDX_CHAN3_LO      14'h045B
`define IDX_CHAN4_SC      14'h045C
`define IDX_CHAN4_HI      14'h045D
`define IDX_CHAN4_LO      14'h045E
`define IDX_CHAN5_SC      14'h045F
`define IDX_CHAN5_HI      14'h0460
`define IDX_CHAN5_LO      14'h0461
`define CHAN_STRIDE       14'h0003
`define IDX_PRESCALE      14'h0470
`define IDX_IRQ_STATUS    14'h0471
`define IDX_IRQ_MASK      14'h0472

// ****************************************************************
// Status and control fields
// ****************************************************************
`define SC_FLAG           7
`define SC_IRQ_EN         6
`define SC_MODE_B         5
`define SC_MODE_A         4
`define SC_EDGE_B         3
`define SC_EDGE_A         2
`define SC_MASK_WITH_B    8'h7F
`define SC_MASK_NO_B      8'h5F
`define SC_RESET          8'h00

// ****************************************************************
// Prescaler
// ****************************************************************
`define PS_EXT_CLOCK      3'h7
`define PS_RESET          3'h0
`define DIV_ONE           7'h01

`endif

// ===== verilog/timer_capture_pkg.sv
/*
 * State types for the input-capture timer block.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
package timer_capture_pkg;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic prev;
  } edge_state_t;

  typedef struct packed {
    logic [5:0]       div;
    logic [2:0]       prescale;
    logic [3:0][7:0]  ctrl;
    logic [3:0][15:0] value;
    logic [3:0]       irq_status;
    logic [3:0]       irq_mask;
    logic [31:0]      rdata;
  } timer_state_t;

endpackage

// ===== verilog/edge_sense.sv
/*
 * Two-flop synchroniser with rising and falling edge pulses.
 * Assumes the pin is asynchronous to clk; pulses last one clock.
 */
`timescale 1ns/1ps

module edge_sense
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin and edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  timer_capture_pkg::edge_state_t st;
  timer_capture_pkg::edge_state_t next_st;

  always_comb
  begin
    next_st.sync_first  = pin;
    next_st.sync_second = st.sync_first;
    next_st.prev        = st.sync_second;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // [RQ17] one pulse per edge
  assign rise = st.sync_second & ~st.prev;
  assign fall = ~st.sync_second & st.prev;

endmodule // edge_sense

// ===== verilog/timer_capture_prescaler.sv
/*
 * Input capture for timer channels 2 to 5 plus counter-clock prescaler,
 * with an APB register slave and a maskable interrupt.
 * Assumes the shared 16-bit counter lives outside, advances on count_tick,
 * and that all pins are sampled on clk.
 */
// The implementer's own choice: the APB interface to the registers.
// Notes on behaviour
// [RQ1] Counter tick from seven bus-clock divisions or the external clock pin.
// [RQ2] Each capture value is a high and low byte register.
// [RQ3] Active pin edge copies the counter into the channel value.
// [RQ4] Two edge select bits choose rising, falling or both edges.
// [RQ5] Every qualifying edge captures, flag set or not.
// [RQ6] Capture sets the channel flag for polling or interrupt.
// [RQ7] Flag with channel interrupt enable raises that channel's request.
// [RQ8] Software reads the value before the next capture overwrites it.
// [RQ9] Reset leaves the capture value registers untouched.
// [RQ10] All channels share the one external 16-bit counter value.
// [RQ11] Period: software captures two same-polarity edges, tracks overflows.
// [RQ12] Pulse width: software captures opposite edges and subtracts.
// [RQ13] Delayed output: software adds delay to capture, writes compare.
// [RQ14] Channel 3 control layout with bit 5 reading zero; resets to zero.
// [RQ15] Channel 4 has mode select B at bit 5; channel 5 does not.
// [RQ16] Channel 4 mode select B links channels 4 and 5.
// [RQ17] Pins are synchronised so one transition gives one capture.
`timescale 1ns/1ps
`include "timer_capture_map.svh"

module timer_capture_prescaler
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Time base
  input  wire logic [15:0] counter_value,
  output logic             count_tick,
  // Channel pins, bit 0 is channel 2
  input  wire logic [3:0]  chan_pin,
  input  wire logic        chan0_pin_ext_clock,
  // Interrupts and mode
  output logic [3:0]       chan_irq,
  output logic             irq,
  output logic             pair45_linked
);

  timer_capture_pkg::timer_state_t st;
  timer_capture_pkg::timer_state_t next_st;

  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;
  logic [3:0]  capture;
  logic        ext_rise;
  logic        hit;
  logic [13:0] index;
  logic        aligned;

  assign index   = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'b00);

  // ****************************************************************
  // Pin synchronisers and capture qualification
  // ****************************************************************
  edge_sense u_ext_edge
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (chan0_pin_ext_clock),
    .rise    (ext_rise),
    .fall    ()
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      logic ic_mode;

      // [RQ17] synchronised edges
      edge_sense u_edge
      (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (chan_pin[g]),
        .rise    (pin_rise[g]),
        .fall    (pin_fall[g])
      );

      if ((g % 2) == 1)
      begin : g_odd
        // [RQ16] linked channel stops capturing
        assign ic_mode = ~st.ctrl[g][`SC_MODE_A] & ~st.ctrl[g-1][`SC_MODE_B];
      end
      else
      begin : g_even
        assign ic_mode = ~st.ctrl[g][`SC_MODE_A] & ~st.ctrl[g][`SC_MODE_B];
      end

      // [RQ4] edge selection
      assign capture[g] = ic_mode &
                          ((st.ctrl[g][`SC_EDGE_A] & pin_rise[g]) |
                           (st.ctrl[g][`SC_EDGE_B] & pin_fall[g]));

      // [RQ7] per-channel request
      assign chan_irq[g] = st.ctrl[g][`SC_FLAG] & st.ctrl[g][`SC_IRQ_EN];
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0] rd;
    logic [5:0]  div_mask;
    logic        wr;
    logic [7:0]  sc_mask;
    logic [13:0] base;
    next_st  = st;
    rd       = 32'h0000_0000;
    hit      = 1'b0;
    wr       = psel & penable & pwrite & aligned;
    div_mask = 6'((`DIV_ONE << st.prescale) - `DIV_ONE);
    sc_mask  = `SC_MASK_WITH_B;
    base     = `IDX_CHAN2_SC;

    // [RQ1] free-running bus-clock divider
    next_st.div = 6'(st.div + 6'h01);

    for (int k = 0; k < 4; k++)
    begin
      base    = 14'(`IDX_CHAN2_SC + 14'(`CHAN_STRIDE * 14'(k)));
      // [RQ14] [RQ15] implemented control bits
      sc_mask = ((k % 2) == 1) ? `SC_MASK_NO_B : `SC_MASK_WITH_B;
      if (index == base)
      begin
        hit = 1'b1;
        rd  = {24'h00_0000, st.ctrl[k]};
        if (wr)
        begin
          next_st.ctrl[k][6:0] = pwdata[6:0] & sc_mask[6:0];
          if (!pwdata[`SC_FLAG])
          begin
            next_st.ctrl[k][`SC_FLAG] = 1'b0;
          end
        end
      end
      // [RQ2] high and low bytes
      if (index == 14'(base + 14'h0001))
      begin
        hit = 1'b1;
        rd  = {24'h00_0000, st.value[k][15:8]};
        if (wr)
        begin
          next_st.value[k][15:8] = pwdata[7:0];
        end
      end
      if (index == 14'(base + 14'h0002))
      begin
        hit = 1'b1;
        rd  = {24'h00_0000, st.value[k][7:0]};
        if (wr)
        begin
          next_st.value[k][7:0] = pwdata[7:0];
        end
      end
    end

    if (index == `IDX_PRESCALE)
    begin
      hit = 1'b1;
      rd  = {29'h0000_0000, st.prescale};
      if (wr)
      begin
        next_st.prescale = pwdata[2:0];
      end
    end
    if (index == `IDX_IRQ_STATUS)
    begin
      hit = 1'b1;
      rd  = {28'h000_0000, st.irq_status};
      if (wr)
      begin
        next_st.irq_status = st.irq_status & ~pwdata[3:0];
      end
    end
    if (index == `IDX_IRQ_MASK)
    begin
      hit = 1'b1;
      rd  = {28'h000_0000, st.irq_mask};
      if (wr)
      begin
        next_st.irq_mask = pwdata[3:0];
      end
    end

    // Captures after writes so a set beats a clear
    for (int k = 0; k < 4; k++)
    begin
      if (capture[k])
      begin
        // [RQ3] [RQ5] [RQ10] latch shared counter
        next_st.value[k] = counter_value;
        // [RQ6] flag and sticky status
        next_st.ctrl[k][`SC_FLAG] = 1'b1;
        next_st.irq_status[k]     = 1'b1;
      end
    end

    // Read data sampled in the setup phase
    if (psel && !penable)
    begin
      next_st.rdata = (hit && aligned) ? rd : 32'h0000_0000;
    end

    count_tick = 1'b0;
    // [RQ1] tick source select
    if (st.prescale == `PS_EXT_CLOCK)
    begin
      count_tick = ext_rise;
    end
    else
    begin
      count_tick = ((st.div & div_mask) == div_mask);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // [RQ9] capture values keep their contents
      st.div        <= '0;
      st.prescale   <= `PS_RESET;
      st.ctrl       <= {4{`SC_RESET}};
      st.irq_status <= '0;
      st.irq_mask   <= '0;
      st.rdata      <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata        = st.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~(hit & aligned);
  assign irq           = |(st.irq_status & st.irq_mask);
  // [RQ16] buffered pair on channel 4 pin
  assign pair45_linked = st.ctrl[2][`SC_MODE_B];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_VALUE_LOAD: assert property (capture[0] |=> st.value[0] == $past(counter_value)) // [RQ3]
    else $error("Capture did not load counter value");

  AST_OVERWRITE: assert property ((capture[1] && st.ctrl[1][`SC_FLAG])
                                  |=> st.value[1] == $past(counter_value)) // [RQ5]
    else $error("Capture with flag set did not overwrite");

  AST_FLAG_SET: assert property (capture[2] |=> st.ctrl[2][`SC_FLAG] && st.irq_status[2]) // [RQ6]
    else $error("Capture did not set flags");

  AST_IRQ_REQ: assert property ((capture[3] && st.ctrl[3][`SC_IRQ_EN]
                                 && !(psel && penable && pwrite)) |=> chan_irq[3]) // [RQ7]
    else $error("Enabled capture gave no request");

  AST_EDGE_SEL: assert property ((pin_rise[0] && !st.ctrl[0][`SC_EDGE_A]
                                  && !pin_fall[0]) |-> !capture[0]) // [RQ4]
    else $error("Capture on unselected edge");

  AST_DIV_TWO: assert property ((st.prescale == 3'h1 && count_tick
                                 && !(psel && penable && pwrite)) |=> !count_tick) // [RQ1]
    else $error("Divide by two ticked twice");

  AST_EXT_TICK: assert property ((st.prescale == `PS_EXT_CLOCK) |-> count_tick == ext_rise) // [RQ1]
    else $error("External tick mismatch");

  AST_BIT5_ZERO: assert property (!st.ctrl[1][`SC_MODE_B] && !st.ctrl[3][`SC_MODE_B]) // [RQ14]
    else $error("Unimplemented bit set");

  AST_LINKED: assert property (st.ctrl[2][`SC_MODE_B] |-> !capture[3]) // [RQ16]
    else $error("Linked channel captured");

  AST_ONE_PULSE: assert property (capture[0] |=> !capture[0]) // [RQ17]
    else $error("One edge captured twice");

  COV_CAPTURE: cover property (capture[0] ##[1:20] capture[0]);
  COV_IRQ: cover property (capture[1] ##[1:4] irq);
  COV_EXT: cover property (st.prescale == `PS_EXT_CLOCK && count_tick);
  COV_ERR: cover property (pslverr);

endmodule // timer_capture_prescaler

// ===== sim/pin_source.sv
/*
 * Far-side model: signal sources on the channel pins and the
 * external clock pin. Assumes the block samples pins on clk.
 */
`timescale 1ns/1ps

module pin_source
(
  // Clock
  input  wire logic clk,
  // Pins
  output logic [3:0] chan_pin,
  output logic       ext_pin
);
  initial chan_pin = 4'h0;
  initial ext_pin = 1'b0;

  task automatic drive(input int ch, input logic v);
    @(posedge clk);
    chan_pin[ch] <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // pin_source

// ===== sim/testbench.sv
/*
 * Self-checking bench for the capture timer and prescaler.
 * Assumes the register map header and an APB slave with no wait states.
 */
`timescale 1ns/1ps
`include "timer_capture_map.svh"

module testbench;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        count_tick, irq, pair45_linked, ext_pin, err_seen;
  logic [15:0] paddr, counter_value;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  chan_pin, chan_irq;
  int          err_total, check_count, cycles, ticks;

  initial
  begin
    clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; counter_value = 0;
    err_total = 0; check_count = 0; cycles = 0;
  end
  always #20 clk = ~clk;

  timer_capture_prescaler timer_capture_prescaler_i
  (
    .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .counter_value, .count_tick, .chan_pin,
    .chan0_pin_ext_clock(ext_pin), .chan_irq, .irq, .pair45_linked
  );
  pin_source pin_source_i (.clk(clk), .chan_pin(chan_pin), .ext_pin(ext_pin));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic count_ticks(input int n);
    ticks = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (count_tick === 1'b1) ticks++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rchk(`IDX_CHAN3_SC, 32'h0000_0000);
    rchk(`IDX_CHAN4_SC, 32'h0000_0000);
    apb(1'b1, `IDX_CHAN3_SC, 32'h0000_00FF);
    rchk(`IDX_CHAN3_SC, 32'h0000_005F);
    apb(1'b1, `IDX_CHAN5_SC, 32'h0000_00FF);
    rchk(`IDX_CHAN5_SC, 32'h0000_005F);
    apb(1'b1, `IDX_CHAN4_SC, 32'h0000_00FF);
    rchk(`IDX_CHAN4_SC, 32'h0000_007F);
    check(pair45_linked, 32'h0000_0001);
    apb(1'b1, `IDX_CHAN4_SC, 32'h0000_0000);
    check(pair45_linked, 32'h0000_0000);
    apb(1'b1, `IDX_CHAN3_SC, 32'h0000_0000);
    apb(1'b1, `IDX_CHAN5_SC, 32'h0000_0000);
    apb(1'b1, 14'h0400, 32'h0000_00FF);
    check(err_seen, 32'h0000_0001);
    rchk(14'h0400, 32'h0000_0000);
  endtask

  // period from two rising edges; capture read back for a compare sum
  task automatic t_capture();
    apb(1'b1, `IDX_CHAN3_SC, 32'h0000_0044);
    counter_value <= 16'h1234;
    pin_source_i.drive(1, 1'b1);
    rchk(`IDX_CHAN3_HI, 32'h0000_0012);
    rchk(`IDX_CHAN3_LO, 32'h0000_0034);
    rchk(`IDX_CHAN3_SC, 32'h0000_00C4);
    check(chan_irq, 32'h0000_0002);
    check(irq, 32'h0000_0000);
    counter_value <= 16'hABCD;
    pin_source_i.drive(1, 1'b0);
    rchk(`IDX_CHAN3_LO, 32'h0000_0034);
    pin_source_i.drive(1, 1'b1);
    rchk(`IDX_CHAN3_HI, 32'h0000_00AB);
    rchk(`IDX_IRQ_STATUS, 32'h0000_0002);
    apb(1'b1, `IDX_IRQ_MASK, 32'h0000_0002);
    check(irq, 32'h0000_0001);
    apb(1'b1, `IDX_IRQ_STATUS, 32'h0000_0002);
    check(irq, 32'h0000_0000);
    apb(1'b1, `IDX_CHAN3_SC, 32'h0000_0044);
    check(chan_irq, 32'h0000_0000);
  endtask

  task automatic t_edges();
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `IDX_CHAN5_SC, 32'(m << 2));
      apb(1'b1, `IDX_CHAN5_LO, 32'h0000_0000);
      counter_value <= 16'h0010;
      pin_source_i.drive(3, 1'b1);
      rchk(`IDX_CHAN5_LO, (m & 1) ? 32'h0000_0010 : 32'h0000_0000);
      counter_value <= 16'h0020;
      pin_source_i.drive(3, 1'b0);
      rchk(`IDX_CHAN5_LO, (m & 2) ? 32'h0000_0020 :
           ((m & 1) ? 32'h0000_0010 : 32'h0000_0000));
    end
    apb(1'b1, `IDX_CHAN2_SC, 32'h0000_0004);
    counter_value <= 16'h0055;
    pin_source_i.drive(0, 1'b1);
    rchk(`IDX_CHAN2_LO, 32'h0000_0055);
    apb(1'b1, `IDX_CHAN4_SC, 32'h0000_0020);
    apb(1'b1, `IDX_CHAN5_SC, 32'h0000_0004);
    pin_source_i.drive(3, 1'b1);
    rchk(`IDX_CHAN5_SC, 32'h0000_0004);
    apb(1'b1, `IDX_CHAN4_SC, 32'h0000_0000);
  endtask

  task automatic t_prescale();
    for (int n = 0; n < 7; n++)
    begin
      apb(1'b1, `IDX_PRESCALE, 32'(n));
      count_ticks(128);
      check(32'(ticks), 32'(128 >> n));
    end
    apb(1'b1, `IDX_PRESCALE, 32'h0000_0007);
    fork
      count_ticks(40);
      pin_source_i.ext_pulses(4);
    join
    check(32'(ticks), 32'h0000_0004);
    apb(1'b1, `IDX_PRESCALE, 32'h0000_0000);
  endtask

  task automatic t_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(`IDX_CHAN3_HI, 32'h0000_00AB);
    rchk(`IDX_CHAN3_SC, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_capture();
    t_edges();
    t_prescale();
    t_reset();
    conclude();
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      conclude();
    end
  end
endmodule // testbench
